// ### common/ccci_consts.svh
// Register offsets, field positions, reset values and timing counts for the comparator block.
`ifndef CCCI_CONSTS_SVH
`define CCCI_CONSTS_SVH
`define CCCI_OFF_CTRL1      12'h000
`define CCCI_OFF_CTRL2      12'h004
`define CCCI_OFF_SHARED     12'h008
`define CCCI_OFF_FLAGS      12'h00c
`define CCCI_OFF_ENABLES    12'h010
`define CCCI_OFF_IRQCTL     12'h014
`define CCCI_BIT_ENABLE     7
`define CCCI_BIT_RESULT     6
`define CCCI_BIT_PIN_OE     5
`define CCCI_BIT_INVERT     4
`define CCCI_BIT_REF_SEL    2
`define CCCI_CTRL_RESET     8'h00
`define CCCI_TICK_DIV       2'd3
`endif

// ### common/ccci_pkg.sv
// Types shared by the comparator control block.
package ccci_pkg;
   typedef struct packed {
      logic       cmp_enable;
      logic       cmp_pin_output_enable;
      logic       cmp_output_invert;
      logic       pos_input_ref_sel;
      logic [1:0] neg_input_channel_sel;
   } ccci_ctrl_t;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } ccci_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ccci_apb_rsp_t;

   typedef struct packed {
      ccci_ctrl_t [1:0] ctrl;
      logic [1:0]       result;
      logic [1:0]       read_latch;
      logic [1:0]       cycle_latch;
      logic [1:0]       mismatch_prev;
      logic [1:0]       change_flag;
      logic [1:0]       irq_enable;
      logic             periph_en;
      logic             global_en;
      logic [1:0]       tick_cnt;
      logic [31:0]      prdata;
   } ccci_state_t;
endpackage

// ### src/ccci_top.sv
// Control, change detection and interrupt gating for two analog comparators.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ccci_consts.svh"

module ccci_top (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire ccci_pkg::ccci_apb_req_t apb_req,
   output ccci_pkg::ccci_apb_rsp_t      apb_rsp,
   input  wire logic [1:0]             analog_cmp_raw,
   input  wire logic [1:0]             pin_direction_bit,
   input  wire logic [1:0]             port_data_latch,
   output logic [1:0]                  analog_cmp_power_on,
   output logic [3:0]                  analog_neg_sel,
   output logic [1:0]                  analog_pos_ref_sel,
   output logic [1:0]                  cmp_pin_out,
   output logic [1:0]                  cmp_pin_oe,
   output logic                        cmp_irq,
   output logic                        cmp_wake
);
   import ccci_pkg::*;

   // Reset release synchroniser.
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   // Raw comparator outputs arrive from analog cells, so synchronise them.
   logic [1:0]  raw_meta_q;
   logic [1:0]  raw_sync_q;
   ccci_state_t s_q;
   ccci_state_t s_d;
   logic        phase_one_tick;
   logic        wr_acc;
   logic        rd_acc;
   logic [11:0] addr;
   logic [1:0]  pol_res;
   logic [1:0]  mismatch;

   // Release reset through two flip-flops.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Two-stage synchroniser for the analog results.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         raw_meta_q <= 2'h0;
         raw_sync_q <= 2'h0;
      end else begin
         raw_meta_q <= analog_cmp_raw;
         raw_sync_q <= raw_meta_q;
      end
   end

   // Applies the polarity bit to a raw result, gated by the enable.
   function automatic logic polarize(input logic raw, input ccci_ctrl_t c);
      polarize = c.cmp_enable & (raw ^ c.cmp_output_invert);
   endfunction

   // Packs a control register image for read back.
   function automatic logic [31:0] ctrl_image(input ccci_ctrl_t c, input logic res);
      logic [31:0] v;
      v = 32'h0;
      v[`CCCI_BIT_ENABLE]  = c.cmp_enable;
      v[`CCCI_BIT_RESULT]  = res;
      v[`CCCI_BIT_PIN_OE]  = c.cmp_pin_output_enable;
      v[`CCCI_BIT_INVERT]  = c.cmp_output_invert;
      v[`CCCI_BIT_REF_SEL] = c.pos_input_ref_sel;
      v[1:0]               = c.neg_input_channel_sel;
      ctrl_image = v;
   endfunction

   // Unpacks written data into a control register.
   function automatic ccci_ctrl_t ctrl_load(input logic [31:0] w);
      ccci_ctrl_t c;
      c.cmp_enable            = w[`CCCI_BIT_ENABLE];
      c.cmp_pin_output_enable = w[`CCCI_BIT_PIN_OE];
      c.cmp_output_invert     = w[`CCCI_BIT_INVERT];
      c.pos_input_ref_sel     = w[`CCCI_BIT_REF_SEL];
      c.neg_input_channel_sel = w[1:0];
      ctrl_load = c;
   endfunction

   // Bus decode; the slave answers in the access phase with no wait.
   assign addr   = apb_req.paddr[11:0];
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign phase_one_tick = (s_q.tick_cnt == `CCCI_TICK_DIV);

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pol_res[i] = polarize(raw_sync_q[i], s_q.ctrl[i]);
      end
   end

   // Mismatch is the XOR of the two latches; pin enable plays no part.
   assign mismatch = s_q.read_latch ^ s_q.cycle_latch;

   // Next-state logic for all block state.
   always_comb begin
      s_d = s_q;
      s_d.tick_cnt = phase_one_tick ? 2'd0 : s_q.tick_cnt + 2'd1;
      if (phase_one_tick) begin
         s_d.result      = pol_res;
         s_d.cycle_latch = pol_res;
      end
      s_d.mismatch_prev = mismatch;
      for (int i = 0; i < 2; i++) begin
         if (mismatch[i] && !s_q.mismatch_prev[i]) begin
            s_d.change_flag[i] = 1'b1;
         end
      end
      // Read data is captured in the setup cycle and stands until the next setup cycle.
      if (apb_req.psel && !apb_req.penable) begin
         case (addr)
            `CCCI_OFF_CTRL1:   s_d.prdata = ctrl_image(s_q.ctrl[0], s_q.result[0]);
            `CCCI_OFF_CTRL2:   s_d.prdata = ctrl_image(s_q.ctrl[1], s_q.result[1]);
            `CCCI_OFF_SHARED:  s_d.prdata = {30'h0, s_q.result};
            `CCCI_OFF_FLAGS:   s_d.prdata = {30'h0, s_q.change_flag};
            `CCCI_OFF_ENABLES: s_d.prdata = {30'h0, s_q.irq_enable};
            `CCCI_OFF_IRQCTL:  s_d.prdata = {30'h0, s_q.global_en, s_q.periph_en};
            default:           s_d.prdata = 32'h0;
         endcase
      end
      // Any access to a control register (read, or the read inside a write) reloads latch one.
      if (rd_acc || wr_acc) begin
         case (addr)
            `CCCI_OFF_CTRL1: s_d.read_latch[0] = s_q.cycle_latch[0];
            `CCCI_OFF_CTRL2: s_d.read_latch[1] = s_q.cycle_latch[1];
            default:         s_d.read_latch = s_d.read_latch;
         endcase
      end
      if (wr_acc) begin
         case (addr)
            `CCCI_OFF_CTRL1:   s_d.ctrl[0] = ctrl_load(apb_req.pwdata);
            `CCCI_OFF_CTRL2:   s_d.ctrl[1] = ctrl_load(apb_req.pwdata);
            `CCCI_OFF_ENABLES: s_d.irq_enable = apb_req.pwdata[1:0];
            `CCCI_OFF_IRQCTL: begin
               s_d.periph_en = apb_req.pwdata[0];
               s_d.global_en = apb_req.pwdata[1];
            end
            `CCCI_OFF_FLAGS: begin
               // Writing 0 clears, writing 1 sets; a same-cycle hardware set wins.
               for (int i = 0; i < 2; i++) begin
                  s_d.change_flag[i] = apb_req.pwdata[i] |
                     (mismatch[i] & ~s_q.mismatch_prev[i]);
               end
            end
            default: s_d.ctrl = s_d.ctrl;
         endcase
      end
   end

   // State register; reset turns both comparators off.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Analog side controls and pin drive.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         analog_cmp_power_on[i]    = s_q.ctrl[i].cmp_enable;
         analog_neg_sel[2*i +: 2]  = s_q.ctrl[i].neg_input_channel_sel;
         analog_pos_ref_sel[i]     = s_q.ctrl[i].pos_input_ref_sel;
         // Override uses the unlatched result, which is low while the comparator is disabled; the enable also gates the pin drive.
         cmp_pin_out[i] = s_q.ctrl[i].cmp_pin_output_enable ? pol_res[i]
                                                            : port_data_latch[i];
         cmp_pin_oe[i]  = s_q.ctrl[i].cmp_pin_output_enable & s_q.ctrl[i].cmp_enable
                          & ~pin_direction_bit[i];
      end
   end

   // Interrupt and wake gating.
   assign cmp_irq  = |(s_q.change_flag & s_q.irq_enable) & s_q.periph_en & s_q.global_en;
   assign cmp_wake = |(s_q.change_flag & s_q.irq_enable) & s_q.periph_en;

   assign apb_rsp.prdata  = s_q.prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = 1'b0;

   // Assertions.
   a_flag_edge_set: assert property (@(posedge mclk) disable iff (!rst_n)
      (mismatch[0] && !s_q.mismatch_prev[0]) |=> s_q.change_flag[0])
      else $error("Flag 0 not set on mismatch edge.");
   a_read_clears_mm: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_acc && addr == `CCCI_OFF_CTRL1 && !phase_one_tick) |=> !mismatch[0])
      else $error("Read did not clear mismatch 0.");
   a_other_kept: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_acc && addr == `CCCI_OFF_CTRL1) |=> $stable(s_q.read_latch[1]))
      else $error("Read of one comparator disturbed the other.");
   a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_irq |-> (s_q.global_en && s_q.periph_en))
      else $error("Interrupt without enables.");
   a_pin_oe: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_pin_oe[0] |-> (s_q.ctrl[0].cmp_enable && !pin_direction_bit[0]))
      else $error("Pin driven without conditions.");
   a_flag_write: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_acc && addr == `CCCI_OFF_FLAGS && apb_req.pwdata[1]) |=> s_q.change_flag[1])
      else $error("Flag write of one did not set.");
   a_result_tick: assert property (@(posedge mclk) disable iff (!rst_n)
      phase_one_tick |=> (s_q.result == $past(pol_res)))
      else $error("Result not latched on tick.");
   a_disabled_low: assert property (@(posedge mclk) disable iff (!rst_n)
      !s_q.ctrl[0].cmp_enable |-> !pol_res[0])
      else $error("Disabled comparator gave a result.");
endmodule
`default_nettype wire

// ### dv/ccci_analog_model.sv
// Behavioural model of the two analog comparator cells.
`timescale 1ns/10ps
`default_nettype none
module ccci_analog_model (
   input  wire logic                 mclk,
   input  wire logic [1:0]           power_on,
   input  wire logic [3:0]           neg_sel,
   input  wire logic [1:0]           ref_sel,
   input  wire logic [1:0][3:0][7:0] vneg,
   input  wire logic [1:0][7:0]      vpin,
   input  wire logic [7:0]           vref,
   output logic [1:0]                raw
);
   logic [1:0] junk = 2'h1;
   // An unpowered cell gives a toggling level, never a clean answer.
   always @(posedge mclk) junk <= ~junk;
   // Plus input is the reference or the pin; minus is the chosen channel.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         raw[i] = power_on[i] ? ((ref_sel[i] ? vref : vpin[i]) > vneg[i][neg_sel[2*i+:2]])
                              : junk[i];
      end
   end
endmodule
`default_nettype wire

// ### dv/ccci_top_tb.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/10ps
`default_nettype none
`include "ccci_consts.svh"
module ccci_top_tb;
   import ccci_pkg::*;
   logic                 mclk = 1'b0;
   logic                 reset_n = 1'b0;
   ccci_apb_req_t        req = '0;
   ccci_apb_rsp_t        rsp;
   logic [1:0]           raw, pwr, refs, pout, poe;
   logic [1:0]           dir = 2'h3;
   logic [1:0]           pdl = 2'h0;
   logic [3:0]           nsel;
   logic                 irq, wake;
   logic [1:0][3:0][7:0] vneg = '0;
   logic [1:0][7:0]      vpin = '0;
   logic [7:0]           vref = 8'h80;
   logic [31:0]          rd;
   int                   errors = 0;
   int                   checks = 0;

   ccci_top ccci_top_i (.mclk(mclk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
      .analog_cmp_raw(raw), .pin_direction_bit(dir), .port_data_latch(pdl),
      .analog_cmp_power_on(pwr), .analog_neg_sel(nsel), .analog_pos_ref_sel(refs),
      .cmp_pin_out(pout), .cmp_pin_oe(poe), .cmp_irq(irq), .cmp_wake(wake));
   ccci_analog_model ccci_analog_model_i (.mclk(mclk), .power_on(pwr), .neg_sel(nsel),
      .ref_sel(refs), .vneg(vneg), .vpin(vpin), .vref(vref), .raw(raw));

   // Clock of 50 ns period.
   initial begin
      forever #25 mclk = ~mclk;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask

   // One APB transfer; an idle cycle follows so calls may run back to back.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req.paddr <= {20'h0, a};
      req.pwrite <= wr;
      req.pwdata <= d;
      req.psel <= 1'b1;
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         test_done();
      end
      rd = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge mclk);
   endtask

   // Every register and one unmapped word read back zero.
   task automatic rst_chk;
      for (int a = 0; a < 7; a++) begin
         apb(0, 12'(4*a), 0);
         chk("reset value", 0, rd);
      end
   endtask

   task automatic step(input logic [7:0] v, input logic [31:0] e);
      vpin[0] <= v;
      cyc(12);
      apb(0, `CCCI_OFF_FLAGS, 0);
      chk("flags", e, rd);
   endtask

   // Expected result bit for control byte c of comparator i.
   function automatic logic eres(input int i, input logic [7:0] c);
      logic [7:0] vp;
      vp = c[`CCCI_BIT_REF_SEL] ? vref : vpin[i];
      return c[`CCCI_BIT_ENABLE] & ((vp > vneg[i][c[1:0]]) ^ c[`CCCI_BIT_INVERT]);
   endfunction

   initial begin
      logic [7:0]  c;
      logic [11:0] off;
      int          ci;
      void'($urandom(32'h12b2ba56));
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      cyc(3);
      rst_chk();
      $display("test reset done");
      // Random settings; result seen in both registers and at the pin.
      for (int k = 0; k < 24; k++) begin
         ci = k % 2;
         vpin <= 16'($urandom);
         vneg[ci] <= $urandom;
         vref <= 8'($urandom);
         dir <= 2'($urandom);
         pdl <= 2'($urandom);
         c = 8'($urandom) & 8'hb7;
         off = ci ? `CCCI_OFF_CTRL2 : `CCCI_OFF_CTRL1;
         apb(1, off, {24'h0, c});
         cyc(12);
         apb(0, off, 0);
         chk("ctrl", {c[7], eres(ci, c), c[5:0]}, rd);
         apb(0, `CCCI_OFF_SHARED, 0);
         chk("mirror", eres(ci, c), rd[ci]);
         chk("power", c[7], pwr[ci]);
         chk("nsel", c[1:0], nsel[2*ci+:2]);
         chk("rsel", c[2], refs[ci]);
         chk("pin oe", c[5] & c[7] & ~dir[ci], poe[ci]);
         chk("pin out", c[5] ? eres(ci, c) : pdl[ci], pout[ci]);
      end
      $display("test settings done");
      // Change detection on the first comparator, the second one idle.
      vpin[0] <= 8'h10;
      vneg <= {8{8'h80}};
      apb(1, `CCCI_OFF_CTRL2, 0);
      apb(1, `CCCI_OFF_CTRL1, 32'h80);
      cyc(20);
      apb(0, `CCCI_OFF_CTRL1, 0);
      apb(1, `CCCI_OFF_FLAGS, 0);
      apb(1, `CCCI_OFF_ENABLES, 3);
      apb(1, `CCCI_OFF_IRQCTL, 3);
      chk("quiet", 0, irq);
      step(8'hf0, 1);
      chk("irq", 1, irq);
      chk("wake", 1, wake);
      apb(1, `CCCI_OFF_CTRL1, 32'ha0);
      apb(1, `CCCI_OFF_FLAGS, 0);
      step(8'h10, 1);
      apb(1, `CCCI_OFF_FLAGS, 0);
      step(8'h10, 0);
      step(8'hf0, 0);
      step(8'h10, 1);
      apb(0, `CCCI_OFF_CTRL1, 0);
      apb(1, `CCCI_OFF_FLAGS, 0);
      step(8'hf0, 1);
      apb(1, `CCCI_OFF_FLAGS, 2);
      chk("soft flag", 1, irq);
      apb(1, `CCCI_OFF_IRQCTL, 1);
      chk("no global", 0, irq);
      chk("wake on", 1, wake);
      apb(1, `CCCI_OFF_ENABLES, 0);
      chk("wake off", 0, wake);
      $display("test change done");
      // A second reset in mid-run clears everything.
      reset_n <= 1'b0;
      cyc(2);
      reset_n <= 1'b1;
      cyc(3);
      rst_chk();
      $display("test rerun reset done");
      test_done();
   end
endmodule
`default_nettype wire
